// *** logic/drive_fault_trip_manager.sv ***
/*
  Fault-trip manager: classifies protection detects, stops the drive, reports
  the highest-priority trip and keeps a warning history readable over APB.
  Assumes pins are asynchronous, measurements come from logic on clock_in.
*/
// Added by the designer: the register addresses and the APB interface to the registers.
// What this block does
// - Any enabled fault trips the drive or raises a warning, shown to the keypad
// - Near-simultaneous trips show only the highest-priority trip code
// - Level faults clear themselves when the cause goes, no history kept
// - Latch faults clear only when cause gone and a reset is given
// - Fatal faults survive reset inputs; only power-up reset clears them
// - Motor overload trips above set level when overload select nonzero
// - Output overcurrent trips above twice rated current
// - Overvoltage trips when DC bus exceeds its limit
// - Undervoltage is a level trip while DC bus is low
// - Output ground fault above its threshold trips
// - Motor thermal model trips when thermal select nonzero
// - Output phase loss trips only when phase-loss select bit five is set
// - Drive overload model allows 150 percent for one minute
// - Unstable input or charge circuit fault gives a fatal trip
// - Power returning within one second of undervoltage may cause charge trip
// - Heatsink overheat trips
// - Faulty power-switch thermistor trips
// - Cooling fan fault trips
// - External make trip on input closing, break trip on input opening
// - Processor link silent over 500 ms trips
// - Brake relay function with current below release level trips
// - Five warning history registers are readable
`timescale 1ns/1ps
module drive_fault_trip_manager
  import drive_trip_pkg::*;
#(
  parameter int TICK_CYC = TICK_CYCLES,
  parameter int HEAT_LIM = HEAT_LIMIT,
  parameter int LINK_CYC = LINK_CYCLES,
  parameter int CHARGE_CYC = CHARGE_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Sensing
  input wire drive_trip_pkg::pins_s pins_in,
  input wire drive_trip_pkg::meas_s meas_in,
  input wire logic [3:0] warn_in,
  // Drive and keypad
  output logic trip_out,
  output logic warn_out,
  output logic [4:0] trip_code_out,
  output logic [15:0] active_out
);
  import drive_trip_pkg::*;

  if (TICK_CYC < 1 || HEAT_LIM < 1 || LINK_CYC < 2 || CHARGE_CYC < 2)
  begin : g_bad_param
    $error("drive_fault_trip_manager timing parameters out of range");
  end

  // Lowest set index plus one, zero when none
  function automatic logic [4:0] first_hit(input logic [15:0] vec);
    logic [4:0] code;
    code = 5'h00;
    for (int k = NFAULT - 1; k >= 0; k--)
      if (vec[k])
        code = 5'(k + 1);
    return code;
  endfunction

  pins_s pin_lvl;
  logic [31:0] sel_ff;
  logic [31:0] level_ff;
  logic [15:0] active_ff;
  logic [15:0] det;
  logic clr_pulse;
  logic rst_pin_q_ff;
  logic alive_q_ff;
  logic uv_q_ff;
  logic [31:0] link_cnt_ff;
  logic [31:0] uv_cnt_ff;
  logic charge_glitch_ff;
  logic [31:0] tick_cnt_ff;
  logic tick;
  logic [1:0] th_trip;
  logic [7:0] th_pct [2];
  logic [3:0] warn_q_ff;
  logic [4:0] hist_ff [WARN_DEPTH];
  logic [4:0] nxt_warn_code;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic brake_mode;

  pin_filter #(
    .WIDTH($bits(pins_s))
  ) u_pin_filter (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .pins_in(pins_in),
    .level_out(pin_lvl)
  );

  // APB decode; zero-wait answer in the access phase
  assign wr_en = psel_in && penable_in && pwrite_in;
  assign rd_en = psel_in && !penable_in && !pwrite_in;
  assign addr_ok = (paddr_in <= ADDR_WARN0 + 8'(4 * (WARN_DEPTH - 1))) && (paddr_in[1:0] == 2'b00);
  assign pready_out = psel_in && penable_in;
  assign pslverr_out = psel_in && penable_in && !addr_ok;

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      sel_ff <= SEL_RST;
      level_ff <= LEVEL_RST;
    end
    else if (wr_en && paddr_in == ADDR_SEL)
      sel_ff <= pwdata_in;
    else if (wr_en && paddr_in == ADDR_LEVEL)
      level_ff <= {16'h0000, pwdata_in[15:0]};
  end

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
      prdata_out <= 32'h0000_0000;
    else if (rd_en)
    begin
      prdata_out <= 32'h0000_0000;
      if (paddr_in == ADDR_SEL)
        prdata_out <= sel_ff;
      else if (paddr_in == ADDR_LEVEL)
        prdata_out <= level_ff;
      else if (paddr_in == ADDR_STATUS)
        prdata_out <= {16'h0000, active_ff};
      else if (paddr_in == ADDR_CODE)
        prdata_out <= {27'h0, trip_code_out};
      else
        for (int w = 0; w < WARN_DEPTH; w++)
          if (paddr_in == ADDR_WARN0 + 8'(4 * w))
            prdata_out <= {27'h0, hist_ff[w]};
    end
  end

  // Fault reset from the register or the reset pin edge
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
      rst_pin_q_ff <= 1'b0;
    else
      rst_pin_q_ff <= pin_lvl.fault_reset;
  end
  assign clr_pulse = (wr_en && paddr_in == ADDR_RESET && pwdata_in[0]) || (pin_lvl.fault_reset && !rst_pin_q_ff);

  // Millisecond tick for the thermal models
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in || tick)
      tick_cnt_ff <= 32'h0000_0000;
    else
      tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
  end
  assign tick = (tick_cnt_ff == 32'(TICK_CYC - 1));

  // Inverse-time integrators: drive overload and motor thermal
  assign th_pct[0] = meas_in.drive_load_pct;
  assign th_pct[1] = meas_in.out_current_pct;
  genvar t;
  for (t = 0; t < 2; t++)
  begin : g_heat
    logic [31:0] heat_ff;
    always_ff @(posedge clock_in)
    begin
      if (!resetn_in)
        heat_ff <= 32'h0000_0000;
      else if (tick && th_pct[t] > RATED_PCT)
        heat_ff <= heat_ff + 32'(th_pct[t] - RATED_PCT);
      else if (tick && heat_ff > 32'(RATED_PCT - th_pct[t]))
        heat_ff <= heat_ff - 32'(RATED_PCT - th_pct[t]);
      else if (tick)
        heat_ff <= 32'h0000_0000;
    end
    assign th_trip[t] = (heat_ff >= 32'(HEAT_LIM));
  end

  // Processor link watchdog restarted by any change of the alive pin
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      alive_q_ff <= 1'b0;
      link_cnt_ff <= 32'h0000_0000;
    end
    else
    begin
      alive_q_ff <= pin_lvl.ipc_alive;
      if (pin_lvl.ipc_alive != alive_q_ff)
        link_cnt_ff <= 32'h0000_0000;
      else if (link_cnt_ff < 32'(LINK_CYC))
        link_cnt_ff <= link_cnt_ff + 32'h0000_0001;
    end
  end

  // Short power loss: undervoltage that ends inside the charge window
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      uv_q_ff <= 1'b0;
      uv_cnt_ff <= 32'h0000_0000;
      charge_glitch_ff <= 1'b0;
    end
    else
    begin
      uv_q_ff <= pin_lvl.undervolt;
      charge_glitch_ff <= 1'b0;
      if (pin_lvl.undervolt && uv_cnt_ff < 32'(CHARGE_CYC))
        uv_cnt_ff <= uv_cnt_ff + 32'h0000_0001;
      else if (!pin_lvl.undervolt)
        uv_cnt_ff <= 32'h0000_0000;
      if (!pin_lvl.undervolt && uv_q_ff && uv_cnt_ff < 32'(CHARGE_CYC) && sel_ff[SEL_CHARGE_WIN_BIT])
        charge_glitch_ff <= 1'b1;
    end
  end

  assign brake_mode = (sel_ff[SEL_RLY1_LSB +: 5] == BRAKE_FUNC) || (sel_ff[SEL_RLY2_LSB +: 5] == BRAKE_FUNC);

  // Enabled fault detects
  always_comb
  begin
    det = 16'h0000;
    det[F_CHARGE] = pin_lvl.charge_fault || charge_glitch_ff;
    det[F_OVERCUR] = meas_in.out_current_pct > OC_LIMIT_PCT;
    det[F_GROUND] = pin_lvl.ground;
    det[F_OVERVOLT] = pin_lvl.overvolt;
    det[F_NTC] = pin_lvl.thermistor_open;
    det[F_HEATSINK] = pin_lvl.heatsink_hot;
    det[F_FAN] = pin_lvl.fan_fault;
    det[F_LINK] = link_cnt_ff >= 32'(LINK_CYC);
    det[F_EXT_MAKE] = sel_ff[SEL_EXT_MAKE_BIT] && pin_lvl.ext_make;
    det[F_EXT_BREAK] = sel_ff[SEL_EXT_BREAK_BIT] && !pin_lvl.ext_break_closed;
    det[F_DRV_OL] = th_trip[0];
    det[F_MOT_TH] = (sel_ff[SEL_TH_LSB +: 2] != 2'b00) && th_trip[1];
    det[F_MOT_OL] = (sel_ff[SEL_OL_LSB +: 2] != 2'b00) && (meas_in.motor_load_pct > level_ff[7:0]);
    det[F_PHASE] = sel_ff[SEL_PL_ENABLE_BIT] && (|pin_lvl.phase_open);
    det[F_BRAKE] = brake_mode && pin_lvl.brake_on && (meas_in.out_current_pct < level_ff[15:8]);
    det[F_UNDERVOLT] = pin_lvl.undervolt;
  end

  // Trip classes per bit; a detect in the clearing cycle keeps the trip
  genvar f;
  for (f = 0; f < NFAULT; f++)
  begin : g_trip
    always_ff @(posedge clock_in)
    begin
      if (!resetn_in)
        active_ff[f] <= 1'b0;
      else if (LEVEL_MASK[f])
        active_ff[f] <= det[f];
      else if (FATAL_MASK[f])
        active_ff[f] <= active_ff[f] || det[f];
      else
        active_ff[f] <= det[f] || (active_ff[f] && !clr_pulse);
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      trip_out <= 1'b0;
      trip_code_out <= 5'h00;
    end
    else
    begin
      trip_out <= |active_ff;
      trip_code_out <= first_hit(active_ff);
    end
  end
  assign active_out = active_ff;

  // Warning history, newest first
  assign nxt_warn_code = first_hit({12'h000, warn_in & ~warn_q_ff});
  always_ff @(posedge clock_in)
  begin
    if (!resetn_in)
    begin
      warn_q_ff <= 4'h0;
      warn_out <= 1'b0;
      for (int w = 0; w < WARN_DEPTH; w++)
        hist_ff[w] <= 5'h00;
    end
    else
    begin
      warn_q_ff <= warn_in;
      warn_out <= |warn_in;
      if (nxt_warn_code != 5'h00)
      begin
        hist_ff[0] <= nxt_warn_code;
        for (int w = 1; w < WARN_DEPTH; w++)
          hist_ff[w] <= hist_ff[w-1];
      end
    end
  end

  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!resetn_in);

  a_level_follow: assert property (active_ff[F_UNDERVOLT] == $past(det[F_UNDERVOLT]))
    else $error("undervoltage trip does not follow its detect");
  a_latch_hold: assert property (active_ff[F_OVERVOLT] && !clr_pulse |=> active_ff[F_OVERVOLT])
    else $error("latched trip dropped without reset");
  a_latch_clear: assert property (active_ff[F_FAN] && clr_pulse && !det[F_FAN] |=> !active_ff[F_FAN])
    else $error("latched trip not cleared by reset");
  a_fatal_hold: assert property (active_ff[F_CHARGE] |=> active_ff[F_CHARGE])
    else $error("fatal trip cleared before power-up");
  a_trip_stop: assert property (det != 16'h0000 && det[F_UNDERVOLT] == 1'b0 |=> ##1 trip_out)
    else $error("fault did not stop the drive");
  a_code_prio: assert property (active_ff[F_CHARGE] |=> trip_code_out == 5'h01)
    else $error("highest priority code not shown");
  a_overcur_set: assert property (meas_in.out_current_pct > OC_LIMIT_PCT |=> active_ff[F_OVERCUR])
    else $error("overcurrent did not trip");
  a_ol_gate: assert property (sel_ff[SEL_OL_LSB +: 2] == 2'b00 && !active_ff[F_MOT_OL] |=> !active_ff[F_MOT_OL])
    else $error("overload trip while deselected");
  a_phase_gate: assert property (!sel_ff[SEL_PL_ENABLE_BIT] && !active_ff[F_PHASE] |=> !active_ff[F_PHASE])
    else $error("phase loss trip while deselected");
  a_hist_push: assert property (nxt_warn_code != 5'h00 |=> hist_ff[0] == $past(nxt_warn_code))
    else $error("warning not pushed into history");

  c_latch_reset: cover property (active_ff[F_GROUND] ##1 clr_pulse ##1 !active_ff[F_GROUND]);
  c_two_trips: cover property (active_ff[F_OVERCUR] && active_ff[F_FAN]);
  c_link_loss: cover property ($rose(active_ff[F_LINK]));
  c_warn_read: cover property (rd_en && paddr_in == ADDR_WARN0);

endmodule

// *** logic/drive_trip_pkg.sv ***
/*
  Shared constants and carriers for the drive fault-trip manager.
  Assumes a 250 MHz system clock and a 32-bit APB register bus.
*/
package drive_trip_pkg;

  // Register byte addresses
  localparam logic [7:0] ADDR_SEL = 8'h00;
  localparam logic [7:0] ADDR_LEVEL = 8'h04;
  localparam logic [7:0] ADDR_RESET = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_CODE = 8'h10;
  localparam logic [7:0] ADDR_WARN0 = 8'h14;
  localparam int WARN_DEPTH = 5;

  // Select register fields
  localparam int SEL_OL_LSB = 0;
  localparam int SEL_TH_LSB = 2;
  localparam int SEL_PL_ENABLE_BIT = 5;
  localparam int SEL_EXT_MAKE_BIT = 6;
  localparam int SEL_EXT_BREAK_BIT = 7;
  localparam int SEL_CHARGE_WIN_BIT = 8;
  localparam int SEL_RLY1_LSB = 16;
  localparam int SEL_RLY2_LSB = 24;
  localparam logic [31:0] SEL_RST = 32'h0000_0005;
  localparam logic [31:0] LEVEL_RST = 32'h0000_3296;
  localparam logic [4:0] BRAKE_FUNC = 5'h13;

  // Trip bit positions, index 0 is the highest priority
  localparam int NFAULT = 16;
  localparam int F_CHARGE = 0;
  localparam int F_OVERCUR = 1;
  localparam int F_GROUND = 2;
  localparam int F_OVERVOLT = 3;
  localparam int F_NTC = 4;
  localparam int F_HEATSINK = 5;
  localparam int F_FAN = 6;
  localparam int F_LINK = 7;
  localparam int F_EXT_MAKE = 8;
  localparam int F_EXT_BREAK = 9;
  localparam int F_DRV_OL = 10;
  localparam int F_MOT_TH = 11;
  localparam int F_MOT_OL = 12;
  localparam int F_PHASE = 13;
  localparam int F_BRAKE = 14;
  localparam int F_UNDERVOLT = 15;
  localparam logic [15:0] FATAL_MASK = 16'h0001;
  localparam logic [15:0] LEVEL_MASK = 16'h8000;

  // Limits and timing
  localparam logic [7:0] OC_LIMIT_PCT = 8'hC8;
  localparam logic [7:0] RATED_PCT = 8'h64;
  localparam int OL_EXCESS_PCT = 50;
  localparam int OL_TIME_S = 60;
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int HEAT_LIMIT = OL_EXCESS_PCT * OL_TIME_S * (1000000 / TICK_US);
  localparam int LINK_TIMEOUT_MS = 500;
  localparam int LINK_CYCLES = LINK_TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int CHARGE_WIN_MS = 1000;
  localparam int CHARGE_CYCLES = CHARGE_WIN_MS * 1000 * CLK_MHZ;

  // Pin bundle from the sensing circuits
  typedef struct packed {
    logic overvolt;
    logic undervolt;
    logic ground;
    logic charge_fault;
    logic heatsink_hot;
    logic thermistor_open;
    logic fan_fault;
    logic ext_make;
    logic ext_break_closed;
    logic ipc_alive;
    logic [2:0] phase_open;
    logic brake_on;
    logic fault_reset;
  } pins_s;

  // Measurements in percent of rating, on the system clock
  typedef struct packed {
    logic [7:0] out_current_pct;
    logic [7:0] motor_load_pct;
    logic [7:0] drive_load_pct;
  } meas_s;

endpackage

// *** logic/pin_filter.sv ***
/*
  Three-stage input synchroniser for a bundle of pins.
  Assumes asynchronous pins; the output moves only when stages two and three agree.
*/
`timescale 1ns/1ps
module pin_filter #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // Pins and filtered levels
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] level_out
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  if (WIDTH < 1)
  begin : g_bad_width
    $error("pin_filter WIDTH must be at least 1");
  end

  always_ff @(posedge clock_in)
  begin
    s1_ff <= pins_in;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  genvar i;
  for (i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clock_in)
    begin
      if (!resetn_in)
        level_out[i] <= 1'b0;
      else if (s2_ff[i] == s3_ff[i])
        level_out[i] <= s3_ff[i];
    end
  end

endmodule

// *** testbench/drive_sense_model.sv ***
/*
  Model of the sensing circuits and keypad side of the fault-trip manager.
  Assumes the bench sets detect levels in pins_ff, meas_ff and warn_ff by hierarchical access.
*/
`timescale 1ns/1ps
module drive_sense_model
  import drive_trip_pkg::*;
(
  // Clock and link control
  input wire logic clock_in,
  input wire logic link_on_in,
  // Detect lines
  output drive_trip_pkg::pins_s pins_out,
  output drive_trip_pkg::meas_s meas_out,
  output logic [3:0] warn_out
);
  pins_s pins_ff;
  meas_s meas_ff;
  logic [3:0] warn_ff;
  logic [2:0] beat_ff = 3'h0;
  logic alive_ff = 1'b0;

  initial
  begin
    pins_ff = pins_s'(15'h0040);
    meas_ff = '0;
    warn_ff = 4'h0;
  end

  // Processor heartbeat toggles every eight cycles while the link is up
  always_ff @(posedge clock_in)
  begin
    beat_ff <= beat_ff + 3'h1;
    if (link_on_in && beat_ff == 3'h7)
      alive_ff <= ~alive_ff;
  end

  always_comb
  begin
    pins_out = pins_ff;
    pins_out.ipc_alive = alive_ff;
  end
  assign meas_out = meas_ff;
  assign warn_out = warn_ff;

  // Operator reset pulse, long enough to pass the pin filter
  task automatic press_reset();
    pins_ff.fault_reset <= 1'b1;
    repeat (6) @(posedge clock_in);
    pins_ff.fault_reset <= 1'b0;
  endtask
endmodule

// *** testbench/test_drive_fault_trip_manager.sv ***
/*
  Self-checking bench for the fault-trip manager.
  Assumes the sensing model beside it and shortened timing parameters.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_drive_fault_trip_manager;
  import drive_trip_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic link_on = 1'b1;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, trip, warn, errv;
  logic [4:0] code;
  logic [15:0] active;
  logic [3:0] warn_lvl;
  pins_s pins;
  meas_s meas;
  int fail_count = 0;
  int n_checks = 0;

  always #2 clock = ~clock;

  drive_sense_model i_sense (.clock_in(clock), .link_on_in(link_on), .pins_out(pins), .meas_out(meas),
    .warn_out(warn_lvl));
  drive_fault_trip_manager #(.TICK_CYC(4), .HEAT_LIM(20), .LINK_CYC(50), .CHARGE_CYC(40)) i_dut (
    .clock_in(clock), .resetn_in(resetn), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
    .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .pins_in(pins), .meas_in(meas), .warn_in(warn_lvl), .trip_out(trip), .warn_out(warn),
    .trip_code_out(code), .active_out(active));

  task automatic report_and_stop();
    if (fail_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle keeps a following setup from re-driving psel in this step
    @(posedge clock);
  endtask

  task automatic step(input int n, input string nm, input logic [15:0] act, input logic [4:0] c);
    repeat (n) @(posedge clock);
    @(negedge clock);
    `CHK(nm, act, active)
    `CHK(nm, act != 16'h0, trip)
    `CHK(nm, c, code)
    @(posedge clock);
  endtask

  task automatic clear_all();
    i_sense.pins_ff <= pins_s'(15'h0040);
    i_sense.meas_ff <= '0;
    apb(1'b1, ADDR_SEL, 32'h0);
    repeat (8) @(posedge clock);
    apb(1'b1, ADDR_RESET, 32'h1);
    repeat (4) @(posedge clock);
  endtask

  task automatic t_regs();
    apb(1'b0, ADDR_SEL, 32'h0);
    `CHK("sel", SEL_RST, rdv)
    apb(1'b0, ADDR_LEVEL, 32'h0);
    `CHK("level", LEVEL_RST, rdv)
    apb(1'b0, 8'h28, 32'h0);
    `CHK("unmapped", 1'b1, errv)
    apb(1'b1, ADDR_SEL, 32'h0);
    step(8, "idle", 16'h0, 5'h0);
  endtask

  task automatic t_overcur();
    i_sense.meas_ff.out_current_pct <= OC_LIMIT_PCT;
    step(8, "oc_200", 16'h0, 5'h0);
    i_sense.meas_ff.out_current_pct <= OC_LIMIT_PCT + 8'h01;
    step(4, "oc_201", 16'h0002, 5'h02);
    apb(1'b1, ADDR_RESET, 32'h1);
    step(2, "oc_set_wins", 16'h0002, 5'h02);
    i_sense.meas_ff.out_current_pct <= 8'h00;
    step(4, "oc_held", 16'h0002, 5'h02);
    apb(1'b1, ADDR_RESET, 32'h1);
    step(4, "oc_reset", 16'h0, 5'h0);
  endtask

  task automatic t_level_prio();
    i_sense.pins_ff.undervolt <= 1'b1;
    step(8, "uv", 16'h8000, 5'h10);
    i_sense.pins_ff.undervolt <= 1'b0;
    step(8, "uv_gone", 16'h0, 5'h0);
    i_sense.pins_ff.overvolt <= 1'b1;
    i_sense.pins_ff.ground <= 1'b1;
    step(8, "ov_gnd", 16'h000C, 5'h03);
    i_sense.pins_ff.overvolt <= 1'b0;
    i_sense.pins_ff.ground <= 1'b0;
    i_sense.press_reset();
    step(8, "pin_reset", 16'h0, 5'h0);
  endtask

  task automatic t_table();
    int pb[3] = '{10, 9, 8};
    int fb[3] = '{F_HEATSINK, F_NTC, F_FAN};
    for (int i = 0; i < 3; i++)
    begin
      i_sense.pins_ff[pb[i]] <= 1'b1;
      step(8, "pin_trip", 16'(1 << fb[i]), 5'(fb[i] + 1));
      clear_all();
    end
  endtask

  task automatic t_select();
    i_sense.pins_ff.phase_open <= 3'b010;
    step(8, "phase_off", 16'h0, 5'h0);
    apb(1'b1, ADDR_SEL, 32'h20);
    step(8, "phase_on", 16'h2000, 5'h0E);
    i_sense.pins_ff.phase_open <= 3'b000;
    i_sense.meas_ff.motor_load_pct <= 8'h97;
    step(6, "ol_off", 16'h2000, 5'h0E);
    apb(1'b1, ADDR_SEL, 32'h01);
    step(4, "ol_on", 16'h3000, 5'h0D);
    clear_all();
    i_sense.meas_ff.drive_load_pct <= 8'h97;
    step(12, "drv_ol", 16'h0400, 5'h0B);
    clear_all();
    apb(1'b1, ADDR_SEL, 32'h04);
    i_sense.meas_ff.out_current_pct <= 8'h96;
    step(12, "mot_th", 16'h0800, 5'h0C);
    clear_all();
  endtask

  task automatic t_ext_brake();
    apb(1'b1, ADDR_SEL, 32'hC0);
    i_sense.pins_ff.ext_make <= 1'b1;
    step(8, "make", 16'h0100, 5'h09);
    i_sense.pins_ff.ext_make <= 1'b0;
    i_sense.pins_ff.ext_break_closed <= 1'b0;
    step(8, "break", 16'h0300, 5'h09);
    clear_all();
    apb(1'b1, ADDR_SEL, 32'h0013_0000);
    i_sense.pins_ff.brake_on <= 1'b1;
    i_sense.meas_ff.out_current_pct <= 8'h31;
    step(8, "brake_low", 16'h4000, 5'h0F);
    i_sense.meas_ff.out_current_pct <= 8'h32;
    apb(1'b1, ADDR_RESET, 32'h1);
    step(4, "brake_ok", 16'h0, 5'h0);
    clear_all();
  endtask

  task automatic t_link_fatal();
    link_on <= 1'b0;
    step(70, "link", 16'h0080, 5'h08);
    link_on <= 1'b1;
    clear_all();
    i_sense.pins_ff.charge_fault <= 1'b1;
    step(8, "charge", 16'h0001, 5'h01);
    i_sense.pins_ff.charge_fault <= 1'b0;
    apb(1'b1, ADDR_RESET, 32'h1);
    step(8, "charge_held", 16'h0001, 5'h01);
    resetn <= 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    step(4, "power_up", 16'h0, 5'h0);
    apb(1'b1, ADDR_SEL, 32'h100);
    i_sense.pins_ff.undervolt <= 1'b1;
    step(8, "uv_short", 16'h8000, 5'h10);
    i_sense.pins_ff.undervolt <= 1'b0;
    step(8, "charge_win", 16'h0001, 5'h01);
    apb(1'b1, ADDR_SEL, 32'h0);
  endtask

  task automatic t_warn();
    i_sense.warn_ff <= 4'h4;
    repeat (4) @(posedge clock);
    apb(1'b0, ADDR_WARN0, 32'h0);
    `CHK("warn0", 32'h3, rdv)
    `CHK("warn_out", 1'b1, warn)
    i_sense.warn_ff <= 4'h6;
    repeat (4) @(posedge clock);
    apb(1'b0, ADDR_WARN0 + 8'h04, 32'h0);
    `CHK("warn1", 32'h3, rdv)
    apb(1'b0, ADDR_WARN0, 32'h0);
    `CHK("warn0_new", 32'h2, rdv)
    i_sense.warn_ff <= 4'h0;
  endtask

  initial
  begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    t_regs();
    t_overcur();
    t_level_prio();
    t_table();
    t_select();
    t_ext_brake();
    t_link_fatal();
    t_warn();
    report_and_stop();
  end

  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end
endmodule
